//--- clss_sensor.sv
// sensor end of the link: pixel fifo and scan sequencer
// assumes pins arrive asynchronously and the controller makes shift_clk
`default_nettype none

// ----------------------------------------------------------------------
// pixel fifo
// ----------------------------------------------------------------------
module clss_fifo
	import clss_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [DATA_W-1:0] in_data_i,
	// draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [DATA_W-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [DATA_W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	wire [AW-1:0] wr_inc = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
	wire [AW-1:0] rd_inc = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;

	assign in_ready_o = (cnt_r != (AW + 1)'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem_r[rd_r];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= wr_inc;
			end
			if (pop) begin
				rd_r <= rd_inc;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule : clss_fifo

// ----------------------------------------------------------------------
// sensor sequencer
// ----------------------------------------------------------------------
module clss_sensor
	import clss_pkg::*;
#(
	parameter int DATA_W = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// link pins
	clss_link_if.sensor lnk,
	// end of scan of the preceding sensor
	input wire logic chain_start_i,
	// photo values, one word per physical pixel
	input wire logic pix_valid_i,
	output logic pix_ready_o,
	input wire logic [DATA_W-1:0] pix_data_i,
	// amplifier power
	output logic amp_on_o
);
	clss_state_e state_r;
	clss_state_e state_nxt;
	logic [PIN_N-1:0] sync1_r;
	logic [PIN_N-1:0] sync2_r;
	logic sclk_d_r;
	logic edge_d_r;
	logic hi_r;
	logic [CYC_W-1:0] cyc_r;
	logic [IDX_W-1:0] pix_r;
	logic [DATA_W:0] acc_r;
	logic [1:0] got_r;
	logic [DATA_W:0] video_r;
	logic active_r;
	logic [IDX_W-1:0] index_r;
	logic eos_r;
	logic amp_r;
	logic [DATA_W-1:0] f_data;
	logic f_valid;

	// ------------------------------------------------------------------
	// pin synchroniser and shift clock edges
	// ------------------------------------------------------------------
	wire [PIN_N-1:0] pins = {chain_start_i, lnk.first_in_chain_strap,
		lnk.resolution_select_strap, lnk.global_scan_start, lnk.shift_clk};
	wire sclk_s = sync2_r[PIN_SCLK];
	wire start_s = sync2_r[PIN_START];
	wire res_s = sync2_r[PIN_RES];
	wire first_s = sync2_r[PIN_FIRST];
	wire chain_s = sync2_r[PIN_CHAIN] && !first_s;
	wire fall = sclk_d_r && !sclk_s;
	wire rise = !sclk_d_r && sclk_s;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sclk_d_r <= 1'b0;
			edge_d_r <= 1'b0;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			sclk_d_r <= sclk_s;
			edge_d_r <= fall || rise;
		end
	end

	// ------------------------------------------------------------------
	// mode selected decode
	// ------------------------------------------------------------------
	wire [IDX_W-1:0] last_pix = hi_r ? IDX_W'(PIX_HI)
		: IDX_W'(PIX_LO);
	wire [IDX_W-1:0] eos_pix = hi_r ? IDX_W'(EOS_HI)
		: IDX_W'(EOS_LO);
	wire [1:0] need = hi_r ? 2'd1 : 2'd2;
	wire init_done = (cyc_r == CYC_W'(INIT_CYC));
	wire lead_done = (cyc_r == CYC_W'(CHAIN_LEAD_CYC));
	wire scan_end = (pix_r == last_pix);
	wire in_scan = (state_r == CLSS_SCAN);

	// ------------------------------------------------------------------
	// sequencer, state stepped only by shift clock falling edges, pixel count by both edges
	// ------------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		if (fall) begin
			if (start_s) begin
				state_nxt = CLSS_INIT;
			end else begin
				unique case (state_r)
					CLSS_IDLE: begin
						state_nxt = CLSS_IDLE;
					end
					CLSS_INIT: begin
						if (init_done) begin
							state_nxt = first_s ? CLSS_SCAN : CLSS_WAIT;
						end
					end
					CLSS_WAIT: begin
						if (chain_s) begin
							state_nxt = CLSS_LEAD;
						end
					end
					CLSS_LEAD: begin
						if (lead_done) begin
							state_nxt = CLSS_SCAN;
						end
					end
					CLSS_SCAN: begin
						if (scan_end) begin
							state_nxt = CLSS_IDLE;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_r <= CLSS_IDLE;
			hi_r <= 1'b0;
			cyc_r <= '0;
			pix_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (fall && start_s) begin
				hi_r <= res_s;
			end
			if (state_nxt != state_r || (fall && start_s)) begin
				cyc_r <= CYC_W'(1);
				pix_r <= IDX_W'(1);
			end else if (fall && !in_scan) begin
				cyc_r <= cyc_r + 1'b1;
			end else if (in_scan && (fall || rise)) begin
				pix_r <= pix_r + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// pixel fetch and merge
	// ------------------------------------------------------------------
	wire consume = edge_d_r && in_scan;
	// no fetch past the last slot, so no photo word is lost between lines
	wire fetch = (state_r != CLSS_IDLE) && (got_r != need) && !consume
		&& !(in_scan && scan_end);
	wire popped = fetch && f_valid;

	clss_fifo #(
		.DATA_W(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(pix_valid_i),
		.in_ready_o(pix_ready_o),
		.in_data_i(pix_data_i),
		.out_valid_o(f_valid),
		.out_ready_i(fetch),
		.out_data_o(f_data)
	);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			acc_r <= '0;
			got_r <= '0;
		end else if (state_r == CLSS_IDLE || consume) begin
			acc_r <= '0;
			got_r <= '0;
		end else if (popped) begin
			acc_r <= acc_r + {1'b0, f_data};
			got_r <= got_r + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// slot outputs
	// ------------------------------------------------------------------
	wire eos_hit = in_scan && (pix_r + 1'b1 >= eos_pix) && (pix_r <= eos_pix);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			video_r <= '0;
			active_r <= 1'b0;
			index_r <= '0;
			eos_r <= 1'b0;
			amp_r <= 1'b0;
		end else begin
			amp_r <= in_scan;
			if (edge_d_r) begin
				active_r <= in_scan;
				index_r <= in_scan ? pix_r : '0;
				video_r <= (consume && got_r == need) ? acc_r : '0;
				eos_r <= eos_hit;
			end
		end
	end

	assign lnk.video = video_r;
	assign lnk.video_active = active_r;
	assign lnk.video_index = index_r;
	assign lnk.end_of_scan = eos_r;
	assign amp_on_o = amp_r;
endmodule : clss_sensor

`default_nettype wire

//--- clss_pkg.sv
// constants and types shared by both ends of the line scan link
// assumes a single 40 MHz system clock on both ends
`default_nettype none

package clss_pkg;
	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int SHIFT_PERIOD_NS = 800;
	localparam int MAX_PIXEL_PERIOD_NS = 2000;
	localparam int SHIFT_HALF_CYC = SHIFT_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int HALF_MAX_CYC = MAX_PIXEL_PERIOD_NS / CLK_PERIOD_NS;
	// ------------------------------------------------------------------
	// scan geometry, in shift cycles and pixels
	// ------------------------------------------------------------------
	localparam int INIT_CYC = 55;
	localparam int PIX_HI = 688;
	localparam int PIX_LO = 344;
	localparam int EOS_HI = 668;
	localparam int EOS_LO = 324;
	localparam int CHAIN_LEAD_CYC = (PIX_HI - EOS_HI) / 2;
	localparam int IDX_W = 10;
	localparam int CYC_W = 6;
	localparam int LINE_W = 16;
	localparam int FIFO_DEPTH = 8;
	// ------------------------------------------------------------------
	// pin vector positions inside the sensor synchroniser
	// ------------------------------------------------------------------
	localparam int PIN_SCLK = 0;
	localparam int PIN_START = 1;
	localparam int PIN_RES = 2;
	localparam int PIN_FIRST = 3;
	localparam int PIN_CHAIN = 4;
	localparam int PIN_N = 5;
	// ------------------------------------------------------------------
	// sensor sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		CLSS_IDLE = 5'b00001,
		CLSS_INIT = 5'b00010,
		CLSS_WAIT = 5'b00100,
		CLSS_LEAD = 5'b01000,
		CLSS_SCAN = 5'b10000
	} clss_state_e;
endpackage : clss_pkg

`default_nettype wire

//--- clss_link_if.sv
// pins between the scan controller and one line scan sensor
// assumes the bench ties both ends together and no pin is tristated
`default_nettype none

interface clss_link_if #(
	parameter int DATA_W = 8
);
	import clss_pkg::*;
	logic shift_clk;
	logic global_scan_start;
	logic resolution_select_strap;
	logic first_in_chain_strap;
	logic [DATA_W:0] video;
	logic video_active;
	logic [IDX_W-1:0] video_index;
	logic end_of_scan;

	modport sensor (
		input shift_clk,
		input global_scan_start,
		input resolution_select_strap,
		input first_in_chain_strap,
		output video,
		output video_active,
		output video_index,
		output end_of_scan
	);

	modport ctrl (
		output shift_clk,
		output global_scan_start,
		output resolution_select_strap,
		output first_in_chain_strap,
		input video,
		input video_active,
		input video_index,
		input end_of_scan
	);
endinterface : clss_link_if

`default_nettype wire

//--- clss_ctrl.sv
// controller end: shift clock, global start, straps, video capture
// assumes the sensor end answers within a few clocks of each shift edge
`default_nettype none

module clss_ctrl
	import clss_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int NUM_SENSORS = 1,
	parameter int SHIFT_HALF = SHIFT_HALF_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// link pins
	clss_link_if.ctrl lnk,
	// line request
	input wire logic scan_req_i,
	input wire logic hi_res_i,
	input wire logic first_i,
	output logic busy_o,
	// captured pixels
	output logic pix_valid_o,
	output logic [DATA_W:0] pix_data_o,
	output logic [IDX_W-1:0] pix_index_o,
	output logic eos_o
);
	localparam int HALF = (SHIFT_HALF > HALF_MAX_CYC) ? HALF_MAX_CYC
		: SHIFT_HALF;
	localparam int LINE_HI = INIT_CYC + NUM_SENSORS * (PIX_HI / 2);
	localparam int LINE_LO = INIT_CYC + NUM_SENSORS * (PIX_LO / 2);
	localparam int BW = DATA_W + IDX_W + 3;

	logic [7:0] div_r;
	logic sclk_r;
	logic start_r;
	logic pend_r;
	logic res_r;
	logic first_r;
	logic [LINE_W-1:0] line_r;
	logic [BW-1:0] s1_r;
	logic [BW-1:0] s2_r;
	logic pv_r;
	logic [DATA_W:0] pd_r;
	logic [IDX_W-1:0] pi_r;

	// ------------------------------------------------------------------
	// shift clock divider
	// ------------------------------------------------------------------
	wire tog = (div_r == 8'(HALF - 1));
	wire s_fall = tog && sclk_r;
	wire s_rise = tog && !sclk_r;
	wire [LINE_W-1:0] line_len = res_r ? LINE_W'(LINE_HI)
		: LINE_W'(LINE_LO);

	assign busy_o = pend_r || start_r || (line_r != '0);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			div_r <= '0;
			sclk_r <= 1'b0;
			start_r <= 1'b0;
			pend_r <= 1'b0;
			res_r <= 1'b0;
			first_r <= 1'b0;
			line_r <= '0;
		end else begin
			div_r <= tog ? '0 : div_r + 1'b1;
			if (tog) begin
				sclk_r <= !sclk_r;
			end
			if (scan_req_i && !busy_o) begin
				pend_r <= 1'b1;
				res_r <= hi_res_i;
				first_r <= first_i;
			end
			if (s_rise) begin
				start_r <= pend_r;
				if (pend_r) begin
					pend_r <= 1'b0;
				end
			end
			if (s_fall) begin
				if (start_r) begin
					line_r <= line_len;
				end else if (line_r != '0) begin
					line_r <= line_r - 1'b1;
				end
			end
		end
	end

	assign lnk.shift_clk = sclk_r;
	assign lnk.global_scan_start = start_r;
	assign lnk.resolution_select_strap = res_r;
	assign lnk.first_in_chain_strap = first_r;

	// ------------------------------------------------------------------
	// video capture, sampled late in each half period
	// ------------------------------------------------------------------
	wire [BW-1:0] bundle = {lnk.end_of_scan, lnk.video_active,
		lnk.video_index, lnk.video};
	wire samp = tog && s2_r[BW-2];

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s1_r <= '0;
			s2_r <= '0;
			pv_r <= 1'b0;
			pd_r <= '0;
			pi_r <= '0;
		end else begin
			s1_r <= bundle;
			s2_r <= s1_r;
			pv_r <= samp;
			if (samp) begin
				pd_r <= s2_r[DATA_W:0];
				pi_r <= s2_r[DATA_W+IDX_W:DATA_W+1];
			end
		end
	end

	assign pix_valid_o = pv_r;
	assign pix_data_o = pd_r;
	assign pix_index_o = pi_r;
	assign eos_o = s2_r[BW-1];
endmodule : clss_ctrl

`default_nettype wire

//--- clss_link_sva.sv
// checker of the link pins between scan controller and sensor
// assumes one clock and a shift clock of eight clocks a half period
`default_nettype none

module clss_link_sva
	import clss_pkg::*;
#(
	parameter int DATA_W = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// controller pins
	input wire logic shift_clk,
	input wire logic global_scan_start,
	input wire logic resolution_select_strap,
	input wire logic first_in_chain_strap,
	// sensor pins
	input wire logic [DATA_W:0] video,
	input wire logic video_active,
	input wire logic [IDX_W-1:0] video_index,
	input wire logic end_of_scan
);
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// ------------------------------------------------------------------
	// shift cycle counter since the last start
	// ------------------------------------------------------------------
	logic sh_q_r;
	logic st_fall_r;
	logic [IDX_W-1:0] fall_cnt_r;
	wire logic fall_w = sh_q_r && !shift_clk;
	wire logic [IDX_W-1:0] cnt_nxt = global_scan_start ? '0 :
		fall_cnt_r + 10'h001;
	wire logic [IDX_W-1:0] last_w = resolution_select_strap ?
		IDX_W'(PIX_HI) : IDX_W'(PIX_LO);
	wire logic [IDX_W-1:0] eos_w = resolution_select_strap ?
		IDX_W'(EOS_HI) : IDX_W'(EOS_LO);
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sh_q_r <= 1'b0;
			st_fall_r <= 1'b0;
			fall_cnt_r <= '0;
		end else begin
			sh_q_r <= shift_clk;
			if (fall_w) begin
				st_fall_r <= global_scan_start;
				fall_cnt_r <= cnt_nxt;
			end
		end
	end
	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence s_hold8;
		global_scan_start [*8];
	endsequence
	chk_start_width: assert property (
		$rose(global_scan_start) |-> s_hold8 ##1 s_hold8 ##1
		!global_scan_start) else $error("start width");
	chk_start_single: assert property (
		fall_w && global_scan_start |-> !st_fall_r)
		else $error("start over two falls");
	chk_first_pixel: assert property (
		$rose(video_active) && first_in_chain_strap |->
		fall_cnt_r == IDX_W'(INIT_CYC)) else $error("first pixel");
	chk_index_range: assert property (
		video_active |-> video_index >= 10'h001 &&
		video_index <= last_w) else $error("index range");
	chk_idle_index: assert property (
		!video_active |-> video_index == '0) else $error("idle index");
	chk_index_step: assert property (
		$changed(video_index) && video_active && $past(video_active) |->
		video_index == $past(video_index) + 1'b1)
		else $error("index step");
	chk_edge_paced: assert property (
		$changed(video_index) |-> $past(shift_clk, 3) !=
		$past(shift_clk, 6)) else $error("slot off edge");
	chk_eos_rise: assert property (
		$rose(end_of_scan) |-> video_index == eos_w - 1'b1)
		else $error("end of scan rise");
	chk_eos_fall: assert property (
		$fell(end_of_scan) |-> video_index == eos_w + 1'b1)
		else $error("end of scan fall");
	chk_last_pixel: assert property (
		$fell(video_active) |-> $past(video_index) == last_w)
		else $error("last pixel");
endmodule : clss_link_sva

`default_nettype wire

//--- cascaded_line_scan_sequencer_bench.sv
// bench: controller and one sensor joined by the link
// assumes 40 MHz clock and the shortest shift period
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end

module cascaded_line_scan_sequencer_bench
	import clss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 40000;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic scan_req_i = 1'b0;
	logic hi_res_i = 1'b0;
	logic first_i = 1'b1;
	logic chain_start_i = 1'b0;
	logic pix_valid_i = 1'b0;
	logic [7:0] pix_data_i = 8'h00;
	logic pix_ready_o;
	logic busy_o;
	logic pix_valid_o;
	logic eos_o;
	logic amp_on_o;
	logic [8:0] pix_data_o;
	logic [IDX_W-1:0] pix_index_o;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	int taken = 0;
	clss_link_if #(.DATA_W(8)) lnk ();
	clss_ctrl #(.DATA_W(8), .SHIFT_HALF(8)) i_clss_ctrl (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .lnk(lnk.ctrl),
		.scan_req_i(scan_req_i), .hi_res_i(hi_res_i), .first_i(first_i),
		.busy_o(busy_o), .pix_valid_o(pix_valid_o),
		.pix_data_o(pix_data_o), .pix_index_o(pix_index_o), .eos_o(eos_o));
	clss_sensor #(.DATA_W(8)) i_clss_sensor (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .lnk(lnk.sensor),
		.chain_start_i(chain_start_i), .pix_valid_i(pix_valid_i),
		.pix_ready_o(pix_ready_o), .pix_data_i(pix_data_i),
		.amp_on_o(amp_on_o));
	clss_link_sva #(.DATA_W(8)) chk (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .shift_clk(lnk.shift_clk),
		.global_scan_start(lnk.global_scan_start),
		.resolution_select_strap(lnk.resolution_select_strap),
		.first_in_chain_strap(lnk.first_in_chain_strap),
		.video(lnk.video), .video_active(lnk.video_active),
		.video_index(lnk.video_index), .end_of_scan(lnk.end_of_scan));
	always #12.5 clk_i = ~clk_i;
	// photo word feeder, counting up
	always @(posedge clk_i) begin
		if (pix_valid_i && pix_ready_o) begin
			taken++;
			#2 pix_data_i = pix_data_i + 8'h01;
		end
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("checked=%0d bad=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// one line scan; a non-first sensor gets its chain start late
	task automatic run_line(input logic hr, input logic fs,
		input int last, input int eos, input logic [8:0] first_pix);
		int n;
		int g;
		int idle;
		logic [7:0] prev;
		n = 0;
		g = 0;
		idle = 0;
		prev = 8'h00;
		@(posedge clk_i) #2;
		hi_res_i = hr;
		first_i = fs;
		scan_req_i = 1'b1;
		@(posedge clk_i) #2;
		scan_req_i = 1'b0;
		while (idle < 48) begin
			@(posedge clk_i) #1;
			g++;
			if (g == 1) `CHK(busy_o, 1'b1)
			idle = (busy_o === 1'b0 && pix_valid_o !== 1'b1) ? idle + 1 : 0;
			if (pix_valid_o === 1'b1) begin
				n++;
				`CHK(pix_index_o, IDX_W'(n))
				if (n == 1) `CHK(amp_on_o, 1'b1)
				if (n == 1) `CHK(pix_data_o, first_pix)
				if (hr && n > 1) `CHK(pix_data_o, {1'b0, prev + 8'h01})
				if (!hr) `CHK(pix_data_o[0], 1'b1)
				if (n == eos - 1) `CHK(eos_o, 1'b1)
				if (n == eos) `CHK(lnk.end_of_scan, 1'b1)
				if (n == eos + 1) `CHK(lnk.end_of_scan, 1'b0)
				if (n == eos + 1) `CHK(eos_o, 1'b0)
				prev = pix_data_o[7:0];
			end
			if (!fs && g == 1000) `CHK(IDX_W'(n), 10'h000)
			if (!fs && g == 1000) `CHK(amp_on_o, 1'b0)
			#1;
			scan_req_i = (g == 300);
			chain_start_i = !fs && g >= 1000 && g < 1016;
		end
		`CHK(IDX_W'(n), IDX_W'(last))
		`CHK(amp_on_o, 1'b0)
	endtask : run_line
	initial begin
		repeat (12) @(posedge clk_i);
		#2 rst_b_i = 1'b1;
		pix_valid_i = 1'b1;
		repeat (24) @(posedge clk_i);
		#1 `CHK(taken, 8)
		`CHK(pix_ready_o, 1'b0)
		$display("test fifo fill done");
		run_line(1'b1, 1'b1, PIX_HI, EOS_HI, 9'h000);
		$display("test high res first done");
		run_line(1'b0, 1'b1, PIX_LO, EOS_LO, 9'h161);
		$display("test low res first done");
		run_line(1'b0, 1'b0, PIX_LO, EOS_LO, 9'h0c1);
		$display("test low res chained done");
		end_sim();
	end
endmodule : cascaded_line_scan_sequencer_bench

`undef CHK
`default_nettype wire
